// *** common/sram_pkg.sv ***
package sram_pkg;

  localparam int ADDR_W     = 19;
  localparam int DATA_W     = 32;
  localparam int LANES      = 4;
  localparam int WORD_W     = DATA_W + LANES;
  localparam int LANE_W     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int ENTRY_W    = ADDR_W + WORD_W + LANES;
  localparam int SYNC_W     = 3;

  // levels seen by the synchronisers before the first sampled pin value, then the step a burst start loads
  localparam logic OE_N_RESET = 1'b1;
  localparam logic MODE_RESET = 1'b1;
  localparam logic [1:0] STEP_RESET = 2'h0;

  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } access_type;

endpackage : sram_pkg

// *** rtl/write_fifo.sv ***
module write_fifo
  import sram_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   count;
  } fifo_state_type;

  fifo_state_type s_r;
  fifo_state_type s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_o  = (s_r.count != DEPTH[PW:0]);
  assign out_valid_o = (s_r.count != '0);
  assign out_data_o  = mem[s_r.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
    end
    s_nxt.count = s_r.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[s_r.wr_ptr] <= in_data_i;
    end
  end

endmodule : write_fifo

// *** rtl/burst_sram.sv ***
//Behaviour
//- every synchronous input is sampled at the rising edge; read data leaves a register.
//- write data and parity on the data lines are captured at the rising edge.
//- read data appears one cycle after its address was registered.
//- output enable low lets the pins drive; high tri-states data and parity.
//- mode strap low gives linear order; high or floating gives interleaved.
//- first burst address loads a two-bit wrapping counter producing the rest.
//- burst address advances only when burst advance is sampled low.
//- global write low writes all four lanes, ignoring byte controls.
//- processor strobe is ignored while the first chip select is high.
//- a read starts on a strobe with chip selected and both write controls high.
//- a start stores the address in address register and burst counter at once.
//- at the next edge read data goes to the bus if output enable is low.
//- first cycle after leaving deselect keeps outputs off regardless of output enable.
//- deselect by chip selects with a strobe turns the outputs off at once.
//- back-to-back single reads are accepted without idle cycles.
//- processor-strobe write ignores write controls and advance in its first cycle.
//- processor-strobe write completes at the second edge using global or byte controls.
//- a byte write changes only selected lanes; others stay unchanged.
//- data drivers are off whenever a write cycle is seen.
//- interleaved order is start XOR step.
//- linear order counts up modulo four from the start.
//- with both strobes low and the first chip select low only the processor strobe acts.
//- a controller-strobe write completes in the cycle that captures the address.
module burst_sram
  import sram_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              chip_select_first_n_i,
  input  wire logic              chip_select_second_i,
  input  wire logic              chip_select_third_n_i,
  input  wire logic              processor_addr_strobe_n_i,
  input  wire logic              controller_addr_strobe_n_i,
  input  wire logic              burst_advance_n_i,
  input  wire logic              global_write_n_i,
  input  wire logic              byte_write_enable_n_i,
  input  wire logic [LANES-1:0]  byte_lane_select_n_i,
  input  wire logic              output_enable_n_i,
  input  wire logic              burst_mode_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic [LANES-1:0]  byte_parity_lines_i,
  output logic [DATA_W-1:0]      data_o,
  output logic [LANES-1:0]       byte_parity_lines_o,
  output logic                   data_oe_o
);

  typedef struct packed {
    logic [SYNC_W-1:0] oe_sync;
    logic              oe_n;
    logic [SYNC_W-1:0] mode_sync;
    logic              interleave;
    logic              active;
    logic              proc_pend;
    logic              first;
    access_type        op;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] acc_addr;
    logic [1:0]        start;
    logic [1:0]        step;
    logic [DATA_W-1:0] dout;
    logic [LANES-1:0]  pout;
    logic              oe;
  } sram_state_type;

  sram_state_type s_r;
  sram_state_type s_nxt;

  logic [WORD_W-1:0] mem [1 << ADDR_W];

  function automatic logic [1:0] burst_low(input logic [1:0] start,
                                           input logic [1:0] step,
                                           input logic       interleave);
    burst_low = interleave ? (start ^ step) : (start + step);
  endfunction : burst_low

  // lanes carry eight data bits plus their own parity bit
  function automatic logic [WORD_W-1:0] merge_lanes(input logic [WORD_W-1:0] old_w,
                                                    input logic [WORD_W-1:0] new_w,
                                                    input logic [LANES-1:0]  mask);
    merge_lanes = old_w;
    for (int k = 0; k < LANES; k++) begin
      if (mask[k]) begin
        merge_lanes[k*LANE_W +: LANE_W] = new_w[k*LANE_W +: LANE_W];
        merge_lanes[DATA_W + k]         = new_w[DATA_W + k];
      end
    end
  endfunction : merge_lanes

  logic               selected;
  logic               proc_valid;
  logic               strobe;
  logic               any_write;
  logic [LANES-1:0]   lanes;
  logic [ADDR_W-1:0]  acc_addr;
  logic               wr_valid;
  logic               wr_ready;
  logic [ENTRY_W-1:0] wr_entry;
  logic               head_valid;
  logic               head_ready;
  logic [ENTRY_W-1:0] head;
  logic [ADDR_W-1:0]  head_addr;
  logic [WORD_W-1:0]  head_word;
  logic [LANES-1:0]   head_mask;
  logic [WORD_W-1:0]  rd_word;
  logic               rd_issue;

  assign selected   = !chip_select_first_n_i && chip_select_second_i
                      && !chip_select_third_n_i;
  assign proc_valid = !processor_addr_strobe_n_i && !chip_select_first_n_i;
  assign strobe     = proc_valid || !controller_addr_strobe_n_i;
  assign any_write  = !global_write_n_i
                      || (!byte_write_enable_n_i && (byte_lane_select_n_i != '1));
  assign lanes      = !global_write_n_i ? '1 :
                      (!byte_write_enable_n_i ? ~byte_lane_select_n_i : '0);

  assign {head_addr, head_word, head_mask} = head;
  // the array has one port: a read in flight holds the write drain back a cycle
  assign rd_issue   = (s_r.op == ACC_READ);
  assign head_ready = !rd_issue;
  // at most one write waits at the head, so forwarding from it keeps reads coherent
  assign rd_word    = (head_valid && head_addr == s_r.acc_addr)
                      ? merge_lanes(mem[s_r.acc_addr], head_word, head_mask)
                      : mem[s_r.acc_addr];

  always_comb begin
    s_nxt           = s_r;
    acc_addr        = {s_r.addr[ADDR_W-1:2], burst_low(s_r.start, s_r.step, s_r.interleave)};
    wr_valid        = 1'b0;
    s_nxt.oe_sync   = {s_r.oe_sync[SYNC_W-2:0], output_enable_n_i};
    s_nxt.mode_sync = {s_r.mode_sync[SYNC_W-2:0], burst_mode_i};
    if (s_r.oe_sync[2] == s_r.oe_sync[1]) begin
      s_nxt.oe_n = s_r.oe_sync[2];
    end
    if (s_r.mode_sync[2] == s_r.mode_sync[1]) begin
      s_nxt.interleave = s_r.mode_sync[2];
    end
    s_nxt.first     = 1'b0;
    s_nxt.proc_pend = 1'b0;
    s_nxt.op        = ACC_IDLE;
    if (strobe) begin
      if (!selected) begin
        s_nxt.active = 1'b0;
      end else begin
        s_nxt.active = 1'b1;
        s_nxt.addr   = addr_i;
        s_nxt.start  = addr_i[1:0];
        s_nxt.step   = STEP_RESET;
        s_nxt.first  = !s_r.active;
        acc_addr     = addr_i;
        if (proc_valid) begin
          s_nxt.proc_pend = 1'b1;
          s_nxt.op        = ACC_READ;
        end else if (any_write) begin
          s_nxt.op = ACC_WRITE;
        end else begin
          s_nxt.op = ACC_READ;
        end
      end
    end else if (s_r.active) begin
      if (!burst_advance_n_i && !s_r.proc_pend) begin
        s_nxt.step = s_r.step + 2'h1;
        acc_addr   = {s_r.addr[ADDR_W-1:2],
                      burst_low(s_r.start, s_nxt.step, s_r.interleave)};
      end
      s_nxt.op = any_write ? ACC_WRITE : ACC_READ;
    end
    s_nxt.acc_addr = acc_addr;
    if (s_nxt.op == ACC_WRITE) begin
      wr_valid = 1'b1;
    end
    if (rd_issue) begin
      s_nxt.dout = rd_word[DATA_W-1:0];
      s_nxt.pout = rd_word[WORD_W-1:DATA_W];
    end
    s_nxt.oe = rd_issue && !s_r.first && !s_r.oe_n
               && (s_nxt.op != ACC_WRITE)
               && !(strobe && !selected);
  end

  assign wr_entry = {acc_addr, byte_parity_lines_i, data_i, lanes};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r            <= '0;
      s_r.oe_sync    <= {SYNC_W{OE_N_RESET}};
      s_r.oe_n       <= OE_N_RESET;
      s_r.mode_sync  <= {SYNC_W{MODE_RESET}};
      s_r.interleave <= MODE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (head_valid && head_ready) begin
      mem[head_addr] <= merge_lanes(mem[head_addr], head_word, head_mask);
    end
  end

  write_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_write_fifo (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .in_valid_i (wr_valid),
    .in_ready_o (wr_ready),
    .in_data_i  (wr_entry),
    .out_valid_o(head_valid),
    .out_ready_i(head_ready),
    .out_data_o (head)
  );

  assign data_o              = s_r.dout;
  assign byte_parity_lines_o = s_r.pout;
  assign data_oe_o           = s_r.oe;

  property p_write_off;
    @(posedge clk_i) disable iff (!rstn_i) (s_nxt.op == ACC_WRITE) |=> !data_oe_o;
  endproperty
  a_write_off: assert property (p_write_off)
    else $error("drivers on in a write cycle");

  property p_deselect;
    @(posedge clk_i) disable iff (!rstn_i)
      (strobe && !selected) |=> (!data_oe_o && !s_r.active && s_r.op == ACC_IDLE);
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("deselect did not turn outputs off");

  property p_first_masked;
    @(posedge clk_i) disable iff (!rstn_i)
      (strobe && selected && !s_r.active) |=> ##1 !data_oe_o;
  endproperty
  a_first_masked: assert property (p_first_masked)
    else $error("output on in first cycle after deselect");

  property p_proc_ignored;
    @(posedge clk_i) disable iff (!rstn_i)
      (chip_select_first_n_i && controller_addr_strobe_n_i && !s_r.active)
      |=> (s_r.op == ACC_IDLE);
  endproperty
  a_proc_ignored: assert property (p_proc_ignored)
    else $error("processor strobe acted with first select high");

  property p_load;
    @(posedge clk_i) disable iff (!rstn_i)
      (strobe && selected) |=> (s_r.addr == $past(addr_i) && s_r.step == STEP_RESET
                                && s_r.acc_addr == $past(addr_i));
  endproperty
  a_load: assert property (p_load)
    else $error("start address not loaded");

  property p_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      (s_r.active && !strobe && burst_advance_n_i) |=> $stable(s_r.step) && $stable(s_r.addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("burst address moved without advance");

  property p_advance;
    @(posedge clk_i) disable iff (!rstn_i)
      (s_r.active && !strobe && !burst_advance_n_i && !s_r.proc_pend)
      |=> (s_r.step == $past(s_r.step) + 2'h1);
  endproperty
  a_advance: assert property (p_advance)
    else $error("burst did not advance");

  property p_read_start;
    @(posedge clk_i) disable iff (!rstn_i)
      (strobe && selected && global_write_n_i && byte_write_enable_n_i)
      |=> (s_r.op == ACC_READ) ##1 (data_o == $past(rd_word[DATA_W-1:0]));
  endproperty
  a_read_start: assert property (p_read_start)
    else $error("read not started or data not delivered");

  property p_ctrl_write;
    @(posedge clk_i) disable iff (!rstn_i)
      (!proc_valid && !controller_addr_strobe_n_i && selected && any_write)
      |-> wr_valid && (wr_entry[ENTRY_W-1 -: ADDR_W] == addr_i);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("controller strobe write not issued at once");

  property p_proc_write;
    @(posedge clk_i) disable iff (!rstn_i)
      (proc_valid && selected) ##1 (!strobe && !global_write_n_i)
      |-> wr_valid && (wr_entry[LANES-1:0] == '1) && (acc_addr == s_r.addr);
  endproperty
  a_proc_write: assert property (p_proc_write)
    else $error("processor strobe write missing at second edge");

  property p_linear;
    @(posedge clk_i) disable iff (!rstn_i)
      (s_r.active && !s_r.interleave)
      |-> (s_r.acc_addr[1:0] == s_r.start + s_r.step) || (s_r.op != ACC_READ);
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear burst order broken");

  // the queue drains every write the cycle after it lands, so it must never refuse one
  property p_fifo_room;
    @(posedge clk_i) disable iff (!rstn_i) wr_valid |-> wr_ready;
  endproperty
  a_fifo_room: assert property (p_fifo_room)
    else $error("write queue full, write lost");

  c_back_to_back: cover property (@(posedge clk_i) disable iff (!rstn_i)
    (strobe && selected && s_nxt.op == ACC_READ) ##1 (strobe && selected && s_nxt.op == ACC_READ));
  c_burst4: cover property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.active && s_r.step == 2'h3 && data_oe_o));
  c_byte_write: cover property (@(posedge clk_i) disable iff (!rstn_i)
    (wr_valid && lanes != '1 && lanes != '0));

endmodule : burst_sram

// *** verif/sram_master.sv ***
module sram_master
  import sram_pkg::*;
(
  input  wire logic        clk_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic              chip_select_first_n_o,
  output logic              chip_select_second_o,
  output logic              chip_select_third_n_o,
  output logic              processor_addr_strobe_n_o,
  output logic              controller_addr_strobe_n_o,
  output logic              burst_advance_n_o,
  output logic              global_write_n_o,
  output logic              byte_write_enable_n_o,
  output logic [LANES-1:0]  byte_lane_select_n_o,
  output logic              output_enable_n_o,
  output logic              burst_mode_o,
  output logic [WORD_W-1:0] wdata_o,
  output logic              wdrive_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    addr_o = '0;
    {chip_select_first_n_o, chip_select_second_o, chip_select_third_n_o} = 3'h5;
    {processor_addr_strobe_n_o, controller_addr_strobe_n_o, burst_advance_n_o} = 3'h7;
    {global_write_n_o, byte_write_enable_n_o, output_enable_n_o, burst_mode_o} = 4'hf;
    byte_lane_select_n_o = 4'hf;
    wdata_o = '0;
    wdrive_o = 1'b0;
  end

  // kinds: 0 hold, 1 advance, 2 controller read, 3/4 controller global/byte write,
  // 5 processor start, 6/7 global/byte write second cycle, 8 both strobes,
  // 9 processor strobe with first select off, 10-12 deselect by each select
  task automatic cyc(input int k, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                     input logic [LANES-1:0] sel, input logic oe_n);
    @(posedge clk_i);
    addr_o <= a;
    chip_select_first_n_o <= k inside {9, 10};
    chip_select_second_o <= k != 11;
    chip_select_third_n_o <= k == 12;
    processor_addr_strobe_n_o <= !(k inside {5, 8, 9});
    controller_addr_strobe_n_o <= !(k inside {[2:4], 8, [10:12]});
    // advance and write controls in a processor start must be ignored by the device
    burst_advance_n_o <= !(k inside {1, 5});
    global_write_n_o <= !(k inside {3, 5, 6, 8});
    byte_write_enable_n_o <= !(k inside {4, 7});
    byte_lane_select_n_o <= sel;
    output_enable_n_o <= oe_n;
    // a released bus shows the inverted last value, never a stale copy
    wdrive_o <= k inside {[3:4], [6:7]};
    wdata_o <= (k inside {[3:4], [6:7]}) ? d : ~wdata_o;
  endtask : cyc

  task automatic pins(input logic md);
    burst_mode_o <= md;
  endtask : pins

endmodule : sram_master

// *** verif/burst_sram_test.sv ***
module burst_sram_test;
  import sram_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [WORD_W-1:0] d;
    bit                cd;
    bit                rd;
    bit                first;
    bit                kill;
  } ent_type;

  logic              clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic              chip_select_first_n, chip_select_second, chip_select_third_n;
  logic              processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
  logic              global_write_n, byte_write_enable_n, output_enable_n, burst_mode;
  logic [LANES-1:0]  byte_lane_select_n, byte_parity_lines;
  logic [DATA_W-1:0] data;
  logic [WORD_W-1:0] wdata, pin;
  logic              wdrive, data_oe;
  logic [WORD_W-1:0] mem [int];
  ent_type           p1, p2;
  int                errors, n_tests, seed, base, step, noe, b0, b1;
  bit                rdm, first, oen, m;

  always #12.5 clk_i = ~clk_i;

  // the master overpowers the shared lines while it drives them
  assign pin = (wdrive || !data_oe) ? wdata : {byte_parity_lines, data};

  sram_master bm (.clk_i(clk_i), .addr_o(addr), .chip_select_first_n_o(chip_select_first_n),
    .chip_select_second_o(chip_select_second), .chip_select_third_n_o(chip_select_third_n),
    .processor_addr_strobe_n_o(processor_addr_strobe_n),
    .controller_addr_strobe_n_o(controller_addr_strobe_n),
    .burst_advance_n_o(burst_advance_n), .global_write_n_o(global_write_n),
    .byte_write_enable_n_o(byte_write_enable_n), .byte_lane_select_n_o(byte_lane_select_n),
    .output_enable_n_o(output_enable_n), .burst_mode_o(burst_mode), .wdata_o(wdata),
    .wdrive_o(wdrive));

  burst_sram DUT (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr),
    .chip_select_first_n_i(chip_select_first_n), .chip_select_second_i(chip_select_second),
    .chip_select_third_n_i(chip_select_third_n),
    .processor_addr_strobe_n_i(processor_addr_strobe_n),
    .controller_addr_strobe_n_i(controller_addr_strobe_n),
    .burst_advance_n_i(burst_advance_n), .global_write_n_i(global_write_n),
    .byte_write_enable_n_i(byte_write_enable_n), .byte_lane_select_n_i(byte_lane_select_n),
    .output_enable_n_i(output_enable_n), .burst_mode_i(burst_mode),
    .data_i(pin[DATA_W-1:0]), .byte_parity_lines_i(pin[WORD_W-1:DATA_W]),
    .data_o(data), .byte_parity_lines_o(byte_parity_lines), .data_oe_o(data_oe));

  task automatic chk(input string what, input logic [WORD_W-1:0] exp,
                     input logic [WORD_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : chk

  function automatic int at(int s);
    logic [1:0] lo;
    lo = m ? base[1:0] ^ s[1:0] : base[1:0] + s[1:0];
    return {base[31:2], lo};
  endfunction : at

  task automatic mwr(input int a, input logic [WORD_W-1:0] d, input logic [LANES-1:0] sel_n,
                     input bit g);
    for (int l = 0; l < LANES; l++) begin
      if (g || !sel_n[l]) begin
        mem[a][l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
        mem[a][DATA_W+l] = d[DATA_W+l];
      end
    end
  endtask : mwr

  task automatic setoe(input bit v);
    oen = v;
    // the enable pin crosses a synchroniser, so its checks pause meanwhile
    noe = 6;
  endtask : setoe

  task automatic op(input int k, input int a = 0, input logic [LANES-1:0] sel = 4'h0);
    ent_type e;
    logic [WORD_W-1:0] d;
    d = WORD_W'({$random(seed), $random(seed)});
    // a byte write with every lane deselected is a read, so keep one lane selected
    if (k inside {4, 7} && sel == 4'hf) sel = 4'he;
    bm.cyc(k, ADDR_W'(a), d, sel, oen);
    e = '{default: 0};
    if (k inside {2, 5, 8}) begin
      base = a;
      step = 0;
      rdm = 1;
      e.first = first;
      first = 0;
    end
    if (k == 1) step++;
    if (k inside {3, 4}) first = 0;
    if (k inside {[0:2], 5, 8, 9} && rdm) begin
      e.rd = 1;
      e.cd = k != 5;
      e.d = mem[at(step)];
    end
    if (k inside {3, 4}) mwr(a, d, sel, k == 3);
    if (k inside {6, 7}) mwr(base, d, sel, k == 6);
    if (k inside {[3:4], [6:7], [10:12]}) begin
      rdm = 0;
      e.kill = 1;
      first |= k >= 10;
    end
    @(negedge clk_i);
    if (p2.cd) chk("read data", p2.d, {byte_parity_lines, data});
    if (noe == 0) chk("drive", WORD_W'(p2.rd && !p2.first && !oen && !p1.kill), WORD_W'(data_oe));
    else noe--;
    p2 = p1;
    p1 = e;
  endtask : op

  task automatic restart(input bit md);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    bm.pins(md);
    repeat (7) @(posedge clk_i);
    chk("reset data", '0, {byte_parity_lines, data});
    chk("reset drive", '0, WORD_W'(data_oe));
    rstn_i <= 1'b1;
    m = md;
    first = 1;
    rdm = 0;
    p1 = '{default: 0};
    p2 = p1;
    setoe(1);
    repeat (4) op(0);
  endtask : restart

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  initial begin
    seed = 14444;
    for (int md = 1; md >= 0; md--) begin
      restart(md[0]);
      b0 = $random(seed) & 32'h0007_fff0;
      b1 = b0 + 4;
      for (int i = 0; i < 8; i++) op(3, b0 + i, 4'($random(seed)));
      op(0);
      setoe(0);
      for (int i = 0; i < 4; i++) op(2, b0 + i);
      for (int s = 0; s < 4; s++) begin
        op(2, b1 + s);
        repeat (3) op(1);
        op(0);
        op(9);
      end
      op(8, b0 + 1);
      op(0);
      op(2, b0);
      op(4, b0 + 2, 4'($random(seed)));
      op(2, b0 + 2);
      for (int k = 10; k < 13; k++) begin
        op(k, b0);
        op(9);
        op(2, b0 + 3);
        op(2, b0 + 1);
      end
      setoe(1);
      op(5, b1 + 1);
      op(7, b1 + 1, 4'($random(seed)));
      op(5, b1 + 2);
      op(6, b1 + 2, 4'($random(seed)));
      op(2, b1 + 1);
      op(2, b1 + 2);
      repeat (2) op(0);
      setoe(0);
      repeat (8) op(0);
      $display("burst mode %0d test done, mismatches %0d", md, errors);
    end
    finish_test();
  end

endmodule : burst_sram_test
